// ---- include/fpwm_pkg.sv ----
// constants for the fan pwm and tachometer controller
package fpwm_pkg;
    localparam int unsigned CLK_HZ = 40000000;
    localparam logic [11:0] ADDR_FAN_CFG = 12'h000;
    localparam logic [11:0] ADDR_RATE_DIV = 12'h004;
    localparam logic [11:0] ADDR_TICK_CNT = 12'h008;
    localparam int CFG_DUTY_LSB = 0;
    localparam int CFG_INV_BIT = 8;
    localparam int CFG_OD_BIT = 9;
    localparam int CFG_TOTAL_BIT = 10;
    localparam int CFG_GATE_BIT = 11;
    localparam logic [15:0] RATE_DIV_RESET = 16'h0018;
    localparam logic [11:0] CFG_RESET = 12'h000;
    localparam int unsigned STEPS_PER_PERIOD = 256;
    localparam int unsigned GATE_DELAY_NS = 10000;
    localparam int unsigned GATE_DELAY_CYC = (GATE_DELAY_NS * (CLK_HZ / 1000000) + 999) / 1000;
    localparam int unsigned WINDOW_S = 1;
    localparam int unsigned WINDOW_CYC = WINDOW_S * CLK_HZ;
endpackage : fpwm_pkg

// ---- design/fpwm_wave.sv ----
// pwm waveform generator: rate divider, 8-bit phase, duty compare
`timescale 1ns/1ps
module fpwm_wave (
    input wire logic clk_i,          // core clock
    input wire logic rst_n_i,        // sync reset, active low
    input wire logic [15:0] div_i,   // rate divider
    input wire logic [7:0] duty_i,   // duty setting
    output logic wave_o              // uninverted pwm
);
    logic [15:0] pre_q;
    logic [7:0] phase_q;
    logic step;

    // zero divider treated as one so the phase still advances
    assign step = (pre_q + 16'h0001 >= div_i);

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            pre_q <= 16'h0000;
        end else if (step) begin
            pre_q <= 16'h0000;
        end else begin
            pre_q <= pre_q + 16'h0001;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            phase_q <= 8'h00;
        end else if (step) begin
            phase_q <= phase_q + 8'h01;
        end
    end

    // 255 means fully on, otherwise high for duty steps of 256
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            wave_o <= 1'b0;
        end else begin
            wave_o <= (duty_i == 8'hFF) || (phase_q < duty_i);
        end
    end
endmodule : fpwm_wave

// ---- design/fpwm_rotation_pulse_input.sv ----
// tachometer edge counter with gate delay and one-second window
`timescale 1ns/1ps
module fpwm_rotation_pulse_input #(
    parameter int unsigned WINDOW_CYC = fpwm_pkg::WINDOW_CYC // window length in cycles
) (
    input wire logic clk_i,          // core clock
    input wire logic rst_n_i,        // sync reset, active low
    input wire logic rotation_pulse_input_i,        // synchronised tachometer
    input wire logic pwm_i,          // polarity-corrected pwm
    input wire logic gate_en_i,      // gating enable
    input wire logic total_i,        // free-running total mode
    output logic [15:0] count_o      // readable count
);
    localparam int unsigned DW = $clog2(fpwm_pkg::GATE_DELAY_CYC + 1);
    localparam int unsigned WW = $clog2(WINDOW_CYC + 1);
    logic rotation_pulse_input_q;
    logic [DW-1:0] dly_q;
    logic [WW-1:0] win_q;
    logic [15:0] total_q;
    logic [15:0] run_q;
    logic [15:0] win_cnt_q;
    logic gate_open;
    logic edge_seen;
    logic win_end;

    assign gate_open = !gate_en_i || (pwm_i && dly_q == DW'(fpwm_pkg::GATE_DELAY_CYC));
    assign edge_seen = rotation_pulse_input_i && !rotation_pulse_input_q && gate_open;
    assign win_end = (win_q == WW'(WINDOW_CYC - 1));

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            rotation_pulse_input_q <= 1'b0;
        end else begin
            rotation_pulse_input_q <= rotation_pulse_input_i;
        end
    end

    // gate opens after fixed delay, closes at once on falling pwm
    always_ff @(posedge clk_i) begin
        if (!rst_n_i || !pwm_i) begin
            dly_q <= '0;
        end else if (dly_q != DW'(fpwm_pkg::GATE_DELAY_CYC)) begin
            dly_q <= dly_q + DW'(1);
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i || win_end) begin
            win_q <= '0;
        end else begin
            win_q <= win_q + WW'(1);
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            total_q <= 16'h0000;
        end else if (edge_seen) begin
            total_q <= total_q + 16'h0001;
        end
    end

    // edge on the last window cycle starts the next window
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            run_q <= 16'h0000;
            win_cnt_q <= 16'h0000;
        end else if (win_end) begin
            win_cnt_q <= run_q;
            run_q <= edge_seen ? 16'h0001 : 16'h0000;
        end else if (edge_seen) begin
            run_q <= run_q + 16'h0001;
        end
    end

    // total mode shows the live total, window mode the last latched count
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            count_o <= 16'h0000;
        end else begin
            count_o <= total_i ? total_q : win_cnt_q;
        end
    end
endmodule : fpwm_rotation_pulse_input

// ---- design/fpwm_top.sv ----
// fan pwm and tachometer controller with apb registers
`timescale 1ns/1ps
module fpwm_top #(
    parameter int unsigned WINDOW_CYC = fpwm_pkg::WINDOW_CYC // one-second window
) (
    input wire logic CLOCK_I,          // 40 MHz core clock
    input wire logic RESETN_I,         // sync reset, active low
    input wire logic PSEL_I,           // apb select
    input wire logic PENABLE_I,        // apb enable
    input wire logic PWRITE_I,         // apb direction
    input wire logic [11:0] PADDR_I,   // apb byte address
    input wire logic [31:0] PWDATA_I,  // apb write data
    output logic [31:0] PRDATA_O,      // apb read data
    output logic PREADY_O,             // apb ready
    output logic PSLVERR_O,            // apb error
    input wire logic ROTATION_PULSE_INPUT_I, // rotation pulse input pin
    output logic PWM_O_O,              // pwm pin output value
    output logic PWM_OE_O              // pwm pin output enable
);
    logic [11:0] cfg_q;
    logic [15:0] div_q;
    logic [1:0] rotation_pulse_input_sync_q;
    logic wave;
    logic pwm_corr;
    logic [15:0] tick_count;
    logic wr;
    logic rd;
    logic hit;

    assign wr = PSEL_I && PENABLE_I && PWRITE_I;
    assign rd = PSEL_I && PENABLE_I && !PWRITE_I;
    assign hit = (PADDR_I == fpwm_pkg::ADDR_FAN_CFG) || (PADDR_I == fpwm_pkg::ADDR_RATE_DIV)
        || (PADDR_I == fpwm_pkg::ADDR_TICK_CNT);
    assign PREADY_O = 1'b1;
    assign PSLVERR_O = PSEL_I && PENABLE_I && (!hit || (PWRITE_I
        && PADDR_I == fpwm_pkg::ADDR_TICK_CNT));

    always_ff @(posedge CLOCK_I) begin
        if (!RESETN_I) begin
            cfg_q <= fpwm_pkg::CFG_RESET;
        end else if (wr && PADDR_I == fpwm_pkg::ADDR_FAN_CFG) begin
            cfg_q <= PWDATA_I[11:0];
        end
    end

    always_ff @(posedge CLOCK_I) begin
        if (!RESETN_I) begin
            div_q <= fpwm_pkg::RATE_DIV_RESET;
        end else if (wr && PADDR_I == fpwm_pkg::ADDR_RATE_DIV) begin
            div_q <= PWDATA_I[15:0];
        end
    end

    always_ff @(posedge CLOCK_I) begin
        if (!RESETN_I) begin
            PRDATA_O <= 32'h0000_0000;
        end else if (PSEL_I && !PENABLE_I && !PWRITE_I) begin
            unique case (PADDR_I)
                fpwm_pkg::ADDR_FAN_CFG: PRDATA_O <= {20'h00000, cfg_q};
                fpwm_pkg::ADDR_RATE_DIV: PRDATA_O <= {16'h0000, div_q};
                fpwm_pkg::ADDR_TICK_CNT: PRDATA_O <= {16'h0000, tick_count};
                default: PRDATA_O <= 32'h0000_0000;
            endcase
        end
    end

    // pin is asynchronous to the core clock
    always_ff @(posedge CLOCK_I) begin
        if (!RESETN_I) begin
            rotation_pulse_input_sync_q <= 2'b00;
        end else begin
            rotation_pulse_input_sync_q <= {rotation_pulse_input_sync_q[0], ROTATION_PULSE_INPUT_I};
        end
    end

    fpwm_wave fpwm_wave_i (
        .clk_i(CLOCK_I),
        .rst_n_i(RESETN_I),
        .div_i(div_q),
        .duty_i(cfg_q[fpwm_pkg::CFG_DUTY_LSB +: 8]),
        .wave_o(wave)
    );

    // gate follows the polarity-corrected wave, i.e. before inversion
    assign pwm_corr = wave;

    fpwm_rotation_pulse_input #(.WINDOW_CYC(WINDOW_CYC)) fpwm_rotation_pulse_input_i (
        .clk_i(CLOCK_I),
        .rst_n_i(RESETN_I),
        .rotation_pulse_input_i(rotation_pulse_input_sync_q[1]),
        .pwm_i(pwm_corr),
        .gate_en_i(cfg_q[fpwm_pkg::CFG_GATE_BIT]),
        .total_i(cfg_q[fpwm_pkg::CFG_TOTAL_BIT]),
        .count_o(tick_count)
    );

    logic pin_level;
    assign pin_level = wave ^ cfg_q[fpwm_pkg::CFG_INV_BIT];

    always_ff @(posedge CLOCK_I) begin
        if (!RESETN_I) begin
            PWM_O_O <= 1'b0;
            PWM_OE_O <= 1'b0;
        end else if (cfg_q[fpwm_pkg::CFG_OD_BIT]) begin
            PWM_O_O <= 1'b0;
            PWM_OE_O <= !pin_level;
        end else begin
            PWM_O_O <= pin_level;
            PWM_OE_O <= 1'b1;
        end
    end
endmodule : fpwm_top

// ---- testbench/fpwm_fan_model.sv ----
// fan model: tachometer pulses at a fixed rate
`timescale 1ns/1ps
module fpwm_fan_model #(
    parameter int TPER = 50 // cycles between rotation_pulse_input pulses
) (
    input wire logic clk_i, // core clock
    input wire logic pwm_i, // pwm pin level
    output logic rotation_pulse_input_o // rotation_pulse_input output
);
    int k = 0;
    logic pwm_q = 1'b0;
    // pulse rate divides the window, so every window sees the same count
    initial rotation_pulse_input_o = 1'b0;
    always @(posedge clk_i) begin
        k <= (k == TPER - 1) ? 0 : k + 1;
        pwm_q <= pwm_i;
        // spike as the drive rises, which the gate delay has to hide
        rotation_pulse_input_o <= (k < 10) || (pwm_i && !pwm_q);
    end
endmodule : fpwm_fan_model

// ---- testbench/fpwm_top_chk.sv ----
// port checker for the fan pwm controller
`timescale 1ns/1ps
module fpwm_top_chk (
    input wire logic CLOCK_I, // clock
    input wire logic RESETN_I, // reset
    input wire logic PSEL_I, // select
    input wire logic PENABLE_I, // enable
    input wire logic PWRITE_I, // write
    input wire logic [11:0] PADDR_I, // address
    input wire logic [31:0] PWDATA_I, // wdata
    input wire logic [31:0] PRDATA_O, // rdata
    input wire logic PSLVERR_O, // error
    input wire logic PWM_O_O, // pin value
    input wire logic PWM_OE_O // pin enable
);
    default clocking @(posedge CLOCK_I); endclocking
    default disable iff (!RESETN_I);
    logic [11:0] cfg_q;
    logic [10:0] qt_q;
    wire acc = PSEL_I & PENABLE_I;
    wire cw = acc & PWRITE_I & (PADDR_I == 12'h000);
    wire rse = PSEL_I & !PENABLE_I & !PWRITE_I;
    // settle window of 1024 cycles holds for any divider, as the checked levels do not depend on the phase
    wire st = qt_q[10];
    always_ff @(posedge CLOCK_I) begin
        if (!RESETN_I || cw) begin
            qt_q <= 11'h000;
        end else if (!st) begin
            qt_q <= qt_q + 11'h001;
        end
    end
    always_ff @(posedge CLOCK_I) begin
        if (!RESETN_I) begin
            cfg_q <= 12'h000;
        end else if (cw) begin
            cfg_q <= PWDATA_I[11:0];
        end
    end
    a_duty_zero: assert property (st && cfg_q[9:0] == 10'h000 |-> !PWM_O_O)
        else $error("pwm not low at zero duty");
    a_duty_full: assert property (st && cfg_q[9:0] == 10'h0FF |-> PWM_O_O)
        else $error("pwm not high at full duty");
    a_inv_full: assert property (st && cfg_q[9:0] == 10'h1FF |-> !PWM_O_O)
        else $error("inverted full duty not low");
    a_od_low: assert property (st && cfg_q[9] |-> !PWM_O_O)
        else $error("open drain value not low");
    a_pp_drive: assert property (st && !cfg_q[9] |-> PWM_OE_O)
        else $error("push pull enable low");
    a_bad_addr: assert property (acc && (PADDR_I > 12'h008 || PWRITE_I && PADDR_I == 12'h008)
        |-> PSLVERR_O)
        else $error("bad access not flagged");
    a_good_addr: assert property (acc && (PADDR_I == 12'h000 || PADDR_I == 12'h004)
        |-> !PSLVERR_O)
        else $error("good access flagged");
    a_rdata_hold: assert property (!$past(rse) |-> $stable(PRDATA_O))
        else $error("read data moved");
endmodule : fpwm_top_chk
bind fpwm_top fpwm_top_chk fpwm_top_chk_i (.CLOCK_I(CLOCK_I), .RESETN_I(RESETN_I),
    .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I),
    .PWDATA_I(PWDATA_I), .PRDATA_O(PRDATA_O), .PSLVERR_O(PSLVERR_O), .PWM_O_O(PWM_O_O),
    .PWM_OE_O(PWM_OE_O));

// ---- testbench/fpwm_top_tb_top.sv ----
// self-checking bench for the fan pwm controller
`timescale 1ns/1ps
module fpwm_top_tb_top;
    typedef struct packed {logic w; logic [11:0] a; logic [31:0] d; logic [31:0] r;
        logic e;} fpwm_row_t;
    fpwm_row_t rows [6] = '{'{1'b0, 12'h000, 32'h0, 32'h0, 1'b0},
        '{1'b0, 12'h004, 32'h0, 32'h18, 1'b0}, '{1'b1, 12'h004, 32'h1FFFF, 32'h0, 1'b0},
        '{1'b0, 12'h004, 32'h0, 32'hFFFF, 1'b0}, '{1'b0, 12'h00C, 32'h0, 32'h0, 1'b1},
        '{1'b1, 12'h008, 32'h5, 32'h0, 1'b1}};
    logic [11:0] lv [3] = '{12'h000, 12'h0FF, 12'h1FF};
    logic [2:0] lx = 3'b010;
    logic [11:0] cf [4] = '{12'h000, 12'h800, 12'h880, 12'h8FF};
    logic [31:0] ex [4] = '{32'h14, 32'h0, 32'h0, 32'h14};
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic pen = 1'b0;
    logic pwr = 1'b0;
    logic [11:0] pa = 12'h000;
    logic [31:0] pwd = 32'h0;
    logic [31:0] prd, rd;
    logic prdy, perr, er, pv, pe, tach, seen;
    int failures = 0;
    int n_tests = 0;
    int cyc = 0;
    int t, tg;
    fpwm_top #(.WINDOW_CYC(1000)) fpwm_top_i (.CLOCK_I(clk), .RESETN_I(rst_n), .PSEL_I(psel),
        .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(pa), .PWDATA_I(pwd), .PRDATA_O(prd),
        .PREADY_O(prdy), .PSLVERR_O(perr), .ROTATION_PULSE_INPUT_I(tach), .PWM_O_O(pv),
        .PWM_OE_O(pe));
    fpwm_fan_model fpwm_fan_model_i (.clk_i(clk), .pwm_i(pe ? pv : 1'b1), .rotation_pulse_input_o(tach));
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic close_out();
        $display("checks %0d failures %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : close_out
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        pa <= a;
        pwd <= d;
        @(posedge clk);
        pen <= 1'b1;
        @(posedge clk);
        while (prdy !== 1'b1) @(posedge clk);
        rd = prd;
        er = perr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask : apb
    initial forever #12.5 clk = ~clk;
    // long enough for one stalled divider wrap on top of the planned run
    always @(posedge clk) begin
        cyc++;
        if (cyc == 95000) begin
            failures++;
            close_out();
        end
    end
    initial begin
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        foreach (rows[i]) begin
            apb(rows[i].w, rows[i].a, rows[i].d);
            if (!rows[i].w) chk("rdata", rd, rows[i].r);
            chk("error", er, rows[i].e);
        end
        apb(1'b1, 12'h004, 32'h1);
        apb(1'b1, 12'h000, 32'h40);
        repeat (2) @(posedge pv);
        t = cyc;
        @(negedge pv);
        chk("high", cyc - t, 32'h40);
        @(posedge pv);
        chk("period", cyc - t, 32'h100);
        for (int i = 0; i < 3; i++) begin
            apb(1'b1, 12'h000, {20'h0, lv[i]});
            repeat (1100) @(posedge clk);
            chk("level", pv, lx[i]);
            chk("drive", pe, 1'b1);
        end
        apb(1'b1, 12'h000, 32'h280);
        seen = 1'b0;
        tg = 0;
        repeat (1100) begin
            @(posedge clk);
            seen = seen | pv;
            tg += pe;
        end
        chk("odvalue", seen, 1'b0);
        chk("odtoggle", tg > 400 && tg < 700, 1'b1);
        foreach (cf[i]) begin
            apb(1'b1, 12'h000, {20'h0, cf[i]});
            repeat (2) begin
                repeat (2500) @(posedge clk);
                apb(1'b0, 12'h008, 32'h0);
                chk("count", rd, ex[i]);
            end
        end
        // captures of the two reads lie exactly 1000 cycles apart
        apb(1'b1, 12'h000, 32'h400);
        apb(1'b0, 12'h008, 32'h0);
        t = rd;
        repeat (997) @(posedge clk);
        apb(1'b0, 12'h008, 32'h0);
        chk("total", rd - t, 32'h14);
        rst_n <= 1'b0;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        apb(1'b0, 12'h004, 32'h0);
        chk("divreset", rd, 32'h18);
        close_out();
    end
endmodule : fpwm_top_tb_top
